// file: hw/fsr_bus_cycle.sv
/*
 * One asynchronous flash bus cycle, read or write, with strobe timing counted in clocks.
 * Assumes start only while idle; data pins are split into in, out and output enable.
 */
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_bus_cycle import fsr_pkg::*; #(
	parameter int AW = 20,
	parameter int DW = 8,
	parameter int RD_CYC = `FSR_RD_CYC,
	parameter int WP_CYC = `FSR_WP_CYC,
	parameter int REC_CYC = `FSR_REC_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic wr,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic done,
	output logic [DW-1:0] rdata,
	output logic [AW-1:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [DW-1:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [DW-1:0] flash_dq_in
);
	fsr_cyc_t st_r, st_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic wr_r, wr_nxt, ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt, doe_r, doe_nxt, done_r, done_nxt;
	logic [AW-1:0] a_r, a_nxt;
	logic [DW-1:0] d_r, d_nxt, rd_r, rd_nxt;

	// Strobe sequencing; data is driven through recovery so it holds past the write edge
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		ce_nxt = ce_r;
		oe_nxt = oe_r;
		we_nxt = we_r;
		doe_nxt = doe_r;
		a_nxt = a_r;
		d_nxt = d_r;
		rd_nxt = rd_r;
		done_nxt = 1'b0;
		case (st_r)
			FSR_CYC_IDLE: if (start) begin
				st_nxt = FSR_CYC_ACT;
				a_nxt = addr;
				d_nxt = wdata;
				wr_nxt = wr;
				ce_nxt = 1'b0;
				we_nxt = !wr;
				oe_nxt = wr;
				doe_nxt = wr;
				cnt_nxt = wr ? 8'(WP_CYC - 1) : 8'(RD_CYC - 1);
			end
			FSR_CYC_ACT: if (cnt_r == 8'h00) begin
				if (!wr_r)
					rd_nxt = flash_dq_in; // Sampled after full access time
				ce_nxt = 1'b1;
				oe_nxt = 1'b1;
				we_nxt = 1'b1;
				st_nxt = FSR_CYC_REC;
				cnt_nxt = 8'(REC_CYC - 1);
			end else begin
				cnt_nxt = cnt_r - 8'h01;
			end
			FSR_CYC_REC: if (cnt_r == 8'h00) begin
				doe_nxt = 1'b0;
				done_nxt = 1'b1;
				st_nxt = FSR_CYC_IDLE;
			end else begin
				cnt_nxt = cnt_r - 8'h01;
			end
			default: st_nxt = FSR_CYC_IDLE;
		endcase
	end

	// Cycle registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= FSR_CYC_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
			ce_r <= 1'b1;
			oe_r <= 1'b1;
			we_r <= 1'b1;
			doe_r <= 1'b0;
			a_r <= '0;
			d_r <= '0;
			rd_r <= '0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			ce_r <= ce_nxt;
			oe_r <= oe_nxt;
			we_r <= we_nxt;
			doe_r <= doe_nxt;
			a_r <= a_nxt;
			d_r <= d_nxt;
			rd_r <= rd_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
	assign rdata = rd_r;
	assign flash_addr = a_r;
	assign flash_ce_n = ce_r;
	assign flash_oe_n = oe_r;
	assign flash_we_n = we_r;
	assign flash_dq_out = d_r;
	assign flash_dq_oe = doe_r;
endmodule : fsr_bus_cycle

// file: hw/fsr_cfg.svh
/*
 * Constants of the flash status-poll host controller: register offsets, status bit positions,
 * flash data bit positions, command defaults and bus timing counts.
 * Assumes a 100 MHz clock and a byte-wide status lane in the low bits of the flash data bus.
 */
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// Register offsets on the software port (byte addresses)
`define FSR_REG_CTRL 8'h00
`define FSR_REG_ADDR 8'h04
`define FSR_REG_WDATA 8'h08
`define FSR_REG_STATUS 8'h0C
`define FSR_REG_RDATA 8'h10
`define FSR_REG_LIMIT 8'h14

// Status register bit positions
`define FSR_ST_BUSY 0
`define FSR_ST_DONE 1
`define FSR_ST_FAIL 2
`define FSR_ST_WINDOW 3
`define FSR_ST_REFUSED 4
`define FSR_ST_UNSURE 5
`define FSR_ST_TIMEOUT 6
`define FSR_ST_READY 7

// Flash data bit positions of the status word
`define FSR_DQ_POLL 7
`define FSR_DQ_TOGGLE 6
`define FSR_DQ_LIMIT 5
`define FSR_DQ_WINDOW 3
`define FSR_DQ_SECTOR 2

// Reset values and command defaults
`define FSR_LIMIT_RST 16'hFFFF
`define FSR_CMD_RESET 8'hF0
`define FSR_CMD_SECTOR 8'h30

// Bus timing: figures in ns, counts rounded up to whole clock cycles
`define FSR_CLK_NS 10
`define FSR_T_RD_NS 70
`define FSR_T_WP_NS 35
`define FSR_T_REC_NS 20
`define FSR_CEIL_CYC(ns) (((ns) + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_RD_CYC `FSR_CEIL_CYC(`FSR_T_RD_NS)
`define FSR_WP_CYC `FSR_CEIL_CYC(`FSR_T_WP_NS)
`define FSR_REC_CYC `FSR_CEIL_CYC(`FSR_T_REC_NS)

`endif

// file: hw/fsr_host_ctrl.sv
/*
 * Host controller for a parallel NOR flash: single bus cycles, toggle-bit status polling
 * with failure recheck and reset, and guarded addition of sectors to a pending erase.
 * Assumes a software port with one-cycle strobes and read data one cycle later, and a
 * flash whose status lane sits in the low byte of its data bus.
 */
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_host_ctrl import fsr_pkg::*; #(
	parameter int AW = 20,
	parameter int DW = 8,
	parameter logic [7:0] CMD_RESET = `FSR_CMD_RESET,
	parameter logic [7:0] CMD_SECTOR = `FSR_CMD_SECTOR
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [AW-1:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [DW-1:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [DW-1:0] flash_dq_in,
	input wire logic ready_busy_output
);
	fsr_state_t st_r, st_nxt;
	fsr_op_t op;
	logic go, cyc_done, pair, tog_run, cmp_clr, cmp_load;
	logic [DW-1:0] cyc_rdata, last;
	logic start_r, start_nxt, cwr_r, cwr_nxt, recheck_r, recheck_nxt;
	logic [DW-1:0] cwd_r, cwd_nxt, rdata_r, rdata_nxt;
	logic [15:0] rounds_r, rounds_nxt, limit_r, limit_nxt;
	logic [AW-1:0] addr_r, addr_nxt;
	logic [DW-1:0] wdata_r, wdata_nxt;
	logic done_r, done_nxt, fail_r, fail_nxt, tmo_r, tmo_nxt, ref_r, ref_nxt;
	logic uns_r, uns_nxt, win_r, win_nxt, rdy_r, rsent_r, rsent_nxt;
	logic [7:0] reads_r, reads_nxt;
	logic [31:0] rd_r, rd_nxt;

	// Register select shared by write and read decoding
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	assign op = fsr_op_t'(reg_wdata[2:0]);
	assign go = reg_wr && hit(reg_addr, `FSR_REG_CTRL) && st_r == FSR_ST_IDLE;
	assign cmp_load = cyc_done && !cwr_r;

	// Software registers; address and data are frozen while an operation runs
	always_comb begin
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		limit_nxt = limit_r;
		if (reg_wr && st_r == FSR_ST_IDLE) begin
			if (hit(reg_addr, `FSR_REG_ADDR))
				addr_nxt = reg_wdata[AW-1:0];
			else if (hit(reg_addr, `FSR_REG_WDATA))
				wdata_nxt = reg_wdata[DW-1:0];
			else if (hit(reg_addr, `FSR_REG_LIMIT))
				limit_nxt = reg_wdata[15:0];
		end
	end

	// Sequencer: every cycle it launches targets addr_r, the valid status address
	always_comb begin
		st_nxt = st_r;
		start_nxt = 1'b0;
		cwr_nxt = cwr_r;
		cwd_nxt = cwd_r;
		recheck_nxt = recheck_r;
		rounds_nxt = rounds_r;
		rdata_nxt = rdata_r;
		done_nxt = done_r;
		fail_nxt = fail_r;
		tmo_nxt = tmo_r;
		ref_nxt = ref_r;
		uns_nxt = uns_r;
		win_nxt = win_r;
		rsent_nxt = rsent_r;
		reads_nxt = reads_r;
		cmp_clr = 1'b0;
		if (cmp_load) begin
			rdata_nxt = cyc_rdata;
			reads_nxt = (reads_r == 8'hFF) ? reads_r : reads_r + 8'h01; // Saturates, never wraps
		end
		case (st_r)
			FSR_ST_IDLE: if (go && op != FSR_OP_NONE) begin
				{done_nxt, fail_nxt, tmo_nxt, ref_nxt, uns_nxt} = 5'h00;
				{recheck_nxt, rsent_nxt} = 2'h0;
				rounds_nxt = 16'h0000;
				reads_nxt = 8'h00;
				cmp_clr = 1'b1;
				start_nxt = 1'b1;
				cwr_nxt = (op == FSR_OP_WRITE);
				cwd_nxt = wdata_r;
				case (op)
					FSR_OP_WRITE: st_nxt = FSR_ST_WR;
					FSR_OP_READ: st_nxt = FSR_ST_RD;
					FSR_OP_POLL: st_nxt = FSR_ST_POLL;
					default: st_nxt = FSR_ST_EA_PRE;
				endcase
			end
			FSR_ST_WR, FSR_ST_RD: if (cyc_done) begin
				done_nxt = 1'b1;
				st_nxt = FSR_ST_IDLE;
			end
			FSR_ST_POLL: if (cyc_done)
				st_nxt = FSR_ST_PEVAL;
			FSR_ST_PEVAL: begin
				start_nxt = 1'b1;
				cwr_nxt = 1'b0;
				st_nxt = FSR_ST_POLL;
				if (!pair) begin
					// Second read of the pair still missing
				end else if (!tog_run) begin
					start_nxt = 1'b0;
					done_nxt = 1'b1;
					st_nxt = FSR_ST_IDLE;
				end else if (recheck_r) begin
					start_nxt = 1'b1;
					cwr_nxt = 1'b1;
					cwd_nxt = DW'(CMD_RESET);
					rsent_nxt = 1'b1;
					st_nxt = FSR_ST_RST;
				end else if (last[`FSR_DQ_LIMIT]) begin
					recheck_nxt = 1'b1;
					cmp_clr = 1'b1;
				end else if (rounds_r == limit_r) begin
					start_nxt = 1'b0;
					tmo_nxt = 1'b1;
					done_nxt = 1'b1;
					st_nxt = FSR_ST_IDLE;
				end else begin
					rounds_nxt = rounds_r + 16'h0001;
					cmp_clr = 1'b1;
				end
			end
			FSR_ST_RST: if (cyc_done) begin
				fail_nxt = 1'b1;
				done_nxt = 1'b1;
				st_nxt = FSR_ST_IDLE;
			end
			FSR_ST_EA_PRE: if (cyc_done) begin
				win_nxt = cyc_rdata[`FSR_DQ_WINDOW];
				if (cyc_rdata[`FSR_DQ_WINDOW]) begin
					ref_nxt = 1'b1;
					done_nxt = 1'b1;
					st_nxt = FSR_ST_IDLE;
				end else begin
					start_nxt = 1'b1;
					cwr_nxt = 1'b1;
					cwd_nxt = DW'(CMD_SECTOR);
					st_nxt = FSR_ST_EA_WR;
				end
			end
			FSR_ST_EA_WR: if (cyc_done) begin
				start_nxt = 1'b1;
				cwr_nxt = 1'b0;
				st_nxt = FSR_ST_EA_POST;
			end
			FSR_ST_EA_POST: if (cyc_done) begin
				win_nxt = cyc_rdata[`FSR_DQ_WINDOW];
				uns_nxt = cyc_rdata[`FSR_DQ_WINDOW]; // Window closed: command may be lost
				done_nxt = 1'b1;
				st_nxt = FSR_ST_IDLE;
			end
			default: st_nxt = FSR_ST_IDLE;
		endcase
	end

	// Read port: data stands in the cycle after the strobe only
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (reg_rd) begin
			if (hit(reg_addr, `FSR_REG_STATUS)) begin
				rd_nxt[`FSR_ST_BUSY] = st_r != FSR_ST_IDLE;
				rd_nxt[`FSR_ST_DONE] = done_r;
				rd_nxt[`FSR_ST_FAIL] = fail_r;
				rd_nxt[`FSR_ST_WINDOW] = win_r;
				rd_nxt[`FSR_ST_REFUSED] = ref_r;
				rd_nxt[`FSR_ST_UNSURE] = uns_r;
				rd_nxt[`FSR_ST_TIMEOUT] = tmo_r;
				rd_nxt[`FSR_ST_READY] = rdy_r;
			end else if (hit(reg_addr, `FSR_REG_ADDR))
				rd_nxt[AW-1:0] = addr_r;
			else if (hit(reg_addr, `FSR_REG_WDATA))
				rd_nxt[DW-1:0] = wdata_r;
			else if (hit(reg_addr, `FSR_REG_RDATA))
				rd_nxt[DW-1:0] = rdata_r;
			else if (hit(reg_addr, `FSR_REG_LIMIT))
				rd_nxt[15:0] = limit_r;
		end
	end

	// All state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= FSR_ST_IDLE;
			{start_r, cwr_r, recheck_r, rsent_r, rdy_r} <= 5'h00;
			{done_r, fail_r, tmo_r, ref_r, uns_r, win_r} <= 6'h00;
			cwd_r <= '0;
			rdata_r <= '0;
			addr_r <= '0;
			wdata_r <= '0;
			rounds_r <= 16'h0000;
			limit_r <= `FSR_LIMIT_RST;
			reads_r <= 8'h00;
			rd_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			{start_r, cwr_r, recheck_r, rsent_r} <= {start_nxt, cwr_nxt, recheck_nxt, rsent_nxt};
			rdy_r <= ready_busy_output;
			{done_r, fail_r, tmo_r} <= {done_nxt, fail_nxt, tmo_nxt};
			{ref_r, uns_r, win_r} <= {ref_nxt, uns_nxt, win_nxt};
			cwd_r <= cwd_nxt;
			rdata_r <= rdata_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rounds_r <= rounds_nxt;
			limit_r <= limit_nxt;
			reads_r <= reads_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign reg_rdata = rd_r;

	// Flash bus cycle engine
	fsr_bus_cycle #(.AW(AW), .DW(DW)) u_cyc (
		.clk(clk),
		.rst_n(rst_n),
		.start(start_r),
		.wr(cwr_r),
		.addr(addr_r),
		.wdata(cwd_r),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.flash_addr(flash_addr),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_in(flash_dq_in)
	);

	// Toggle comparison of successive status reads
	fsr_status_cmp #(.DW(DW)) u_cmp (
		.clk(clk),
		.rst_n(rst_n),
		.clear(cmp_clr),
		.load(cmp_load),
		.rd(cyc_rdata),
		.pair(pair),
		.tog_run(tog_run),
		.tog_sector(),
		.last(last)
	);

	// Failure is only declared after the reset command went out
	property p_reset_after_fail;
		@(posedge clk) disable iff (!rst_n)
		$rose(fail_r) |-> rsent_r && $past(st_r) == FSR_ST_RST && $past(cwd_r) == DW'(CMD_RESET);
	endproperty
	a_reset_after_fail: assert property (p_reset_after_fail) else $error("fail without reset");

	// A closed window refuses the sector command without any write
	property p_window_refuse;
		@(posedge clk) disable iff (!rst_n)
		(st_r == FSR_ST_EA_PRE && cyc_done && cyc_rdata[`FSR_DQ_WINDOW])
			|=> st_r == FSR_ST_IDLE && ref_r && !start_r;
	endproperty
	a_window_refuse: assert property (p_window_refuse) else $error("closed window not refused");

	// Sector command only after a check read with the window still open
	property p_pre_check;
		@(posedge clk) disable iff (!rst_n)
		(start_r && st_r == FSR_ST_EA_WR) |-> cwr_r && !win_r && reads_r == 8'h01;
	endproperty
	a_pre_check: assert property (p_pre_check) else $error("sector write without pre-check");

	// Every sector command is followed at once by a check read
	property p_post_check;
		@(posedge clk) disable iff (!rst_n)
		(st_r == FSR_ST_EA_WR && cyc_done) |=> start_r && !cwr_r ##1 !flash_ce_n && flash_we_n;
	endproperty
	a_post_check: assert property (p_post_check) else $error("no post-check read");

	// Poll reads go to the software-given valid address
	property p_poll_addr;
		@(posedge clk) disable iff (!rst_n)
		(start_r && !cwr_r && st_r == FSR_ST_POLL) |=> flash_addr == addr_r && !flash_ce_n;
	endproperty
	a_poll_addr: assert property (p_poll_addr) else $error("poll at wrong address");

	// The toggle recheck costs two more reads before any failure
	property p_recheck;
		@(posedge clk) disable iff (!rst_n)
		$rose(fail_r) |-> reads_r >= 8'h04 && recheck_r;
	endproperty
	a_recheck: assert property (p_recheck) else $error("failure without toggle recheck");

	property p_poll_ok;
		@(posedge clk) disable iff (!rst_n)
		st_r == FSR_ST_PEVAL && pair && !tog_run;
	endproperty
	c_poll_ok: cover property (p_poll_ok);

	property p_poll_fail;
		@(posedge clk) disable iff (!rst_n)
		$rose(fail_r);
	endproperty
	c_poll_fail: cover property (p_poll_fail);

	property p_erase_added;
		@(posedge clk) disable iff (!rst_n)
		st_r == FSR_ST_EA_POST ##1 st_r == FSR_ST_IDLE && !uns_r;
	endproperty
	c_erase_added: cover property (p_erase_added);

	property p_refused;
		@(posedge clk) disable iff (!rst_n)
		$rose(ref_r);
	endproperty
	c_refused: cover property (p_refused);
endmodule : fsr_host_ctrl

// file: hw/fsr_pkg.sv
/*
 * Types of the flash status-poll host controller: operation codes and state machines.
 * Assumes fsr_cfg.svh for all numeric constants.
 */
package fsr_pkg;
	// Operation codes written to the control register, in this order from 0
	typedef enum logic [2:0] {
		FSR_OP_NONE,
		FSR_OP_WRITE,
		FSR_OP_READ,
		FSR_OP_POLL,
		FSR_OP_ERASE_ADD
	} fsr_op_t;

	// Main sequencer states
	typedef enum logic [3:0] {
		FSR_ST_IDLE,
		FSR_ST_WR,
		FSR_ST_RD,
		FSR_ST_POLL,
		FSR_ST_PEVAL,
		FSR_ST_RST,
		FSR_ST_EA_PRE,
		FSR_ST_EA_WR,
		FSR_ST_EA_POST
	} fsr_state_t;

	// Single flash bus cycle states
	typedef enum logic [1:0] {
		FSR_CYC_IDLE,
		FSR_CYC_ACT,
		FSR_CYC_REC
	} fsr_cyc_t;
endpackage : fsr_pkg

// file: hw/fsr_status_cmp.sv
/*
 * Keeps the last two status reads and reports whether the toggle bits changed between them.
 * Assumes load pulses once per completed read; clear restarts the pair.
 */
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_status_cmp import fsr_pkg::*; #(
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic load,
	input wire logic [DW-1:0] rd,
	output logic pair,
	output logic tog_run,
	output logic tog_sector,
	output logic [DW-1:0] last
);
	logic [1:0] cnt_r, cnt_nxt;
	logic [DW-1:0] prev_r, prev_nxt, last_r, last_nxt;

	// Shift in reads, saturating at a full pair
	always_comb begin
		cnt_nxt = cnt_r;
		prev_nxt = prev_r;
		last_nxt = last_r;
		if (clear) begin
			cnt_nxt = 2'h0;
		end else if (load) begin
			prev_nxt = last_r;
			last_nxt = rd;
			cnt_nxt = (cnt_r == 2'h2) ? 2'h2 : cnt_r + 2'h1;
		end
	end

	// Pair registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
			prev_r <= '0;
			last_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			prev_r <= prev_nxt;
			last_r <= last_nxt;
		end
	end

	assign pair = (cnt_r == 2'h2);
	assign tog_run = prev_r[`FSR_DQ_TOGGLE] != last_r[`FSR_DQ_TOGGLE];
	assign tog_sector = prev_r[`FSR_DQ_SECTOR] != last_r[`FSR_DQ_SECTOR];
	assign last = last_r;
endmodule : fsr_status_cmp

// file: test/fsr_flash_model.sv
/*
 * Behavioural flash that answers the host controller with the status word of each state.
 * Assumes pins change on the bench clock; unlock cycles are not decoded, and the sector
 * is the top address nibble.
 */
`timescale 1ns/1ps
module fsr_flash_model #(
	parameter int LIM = 20,
	parameter int PRD = 3,
	parameter int TO = 200,
	parameter int ER = 300
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [7:0] dq,
	input wire logic [19:0] addr,
	output logic [7:0] dq_dev,
	output logic ready_busy_output,
	input wire logic stuck,
	output logic saw_reset_r,
	output logic [3:0] adds_r
);
	logic prog_r, pend_r, run_r, tog_r, stog_r, lim_r, we_q, oe_q, busy, susp_r, in_sec;
	logic [7:0] pd_r, last_r, st;
	logic [9:0] tmr_r;
	logic [5:0] rd_r;
	logic [3:0] sec_r;
	// Status word per state; idle, and unselected sectors while suspended, show array data
	assign in_sec = addr[19:16] == sec_r;
	assign busy = prog_r | pend_r | (run_r & ~susp_r);
	assign st = prog_r ? {~pd_r[7], tog_r, lim_r, 5'h00}
		: susp_r ? (in_sec ? {1'b1, tog_r, 3'h0, stog_r, 2'h0} : 8'h11)
		: busy ? {1'b0, tog_r, 2'h0, run_r, stog_r, 2'h0} : 8'h11;
	// Released bus shows the inverse of the last value, not a stale copy
	assign dq_dev = (!ce_n && !oe_n) ? st : ~last_r;
	assign ready_busy_output = ~busy;
	// Commands at write ends, toggles at read ends, erase timer per clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{prog_r, pend_r, run_r, tog_r, stog_r, lim_r, saw_reset_r, susp_r} <= '0;
			{we_q, oe_q} <= 2'h3;
			{pd_r, last_r, tmr_r, rd_r, adds_r, sec_r} <= '0;
		end else begin
			we_q <= we_n;
			oe_q <= oe_n;
			// Erase timer pauses while suspended
			if (pend_r || (run_r && !susp_r))
				tmr_r <= tmr_r + 10'h001;
			if (pend_r && tmr_r == TO - 1) begin
				pend_r <= 1'b0;
				run_r <= 1'b1;
				tmr_r <= 10'h000;
			end
			if (run_r && !susp_r && tmr_r == ER - 1)
				run_r <= 1'b0;
			if (!we_q && we_n) begin
				if (dq == 8'hF0 && !run_r) begin
					prog_r <= 1'b0;
					lim_r <= 1'b0;
					saw_reset_r <= 1'b1;
				end else if (dq == 8'hB0 && run_r && !susp_r) begin
					susp_r <= 1'b1;
				end else if (dq == 8'h30 && susp_r && !prog_r) begin
					susp_r <= 1'b0;
				end else if (dq == 8'h30 && !run_r && !prog_r) begin
					pend_r <= 1'b1;
					tmr_r <= 10'h000;
					sec_r <= addr[19:16];
					adds_r <= adds_r + 4'h1;
				end else if (dq == 8'h10 && !busy && !susp_r) begin
					run_r <= 1'b1;
					tmr_r <= 10'h000;
				end else if (!busy && dq != 8'h30 && dq != 8'hF0) begin
					prog_r <= 1'b1;
					pd_r <= dq;
					rd_r <= 6'h00;
				end
			end
			if (!oe_q && oe_n) begin
				last_r <= st;
				rd_r <= rd_r + 6'h01;
				if (busy)
					tog_r <= ~tog_r;
				if ((pend_r || run_r) && in_sec)
					stog_r <= ~stog_r;
				if (prog_r && stuck && rd_r >= LIM - 1)
					lim_r <= 1'b1;
				if (prog_r && !stuck && rd_r >= PRD - 1)
					prog_r <= 1'b0;
			end
		end
	end
endmodule : fsr_flash_model

// file: test/fsr_host_ctrl_tb_top.sv
/*
 * Bench for the flash host controller: register tasks, program, poll and erase scenarios.
 * Assumes the behavioural flash model; one 100 MHz clock.
 */
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_host_ctrl_tb_top;
	import fsr_pkg::*;
	logic clk, rst_n, reg_wr, reg_rd, stuck, ce_n, oe_n, we_n, dq_oe, rb, saw_reset;
	logic [7:0] reg_addr, dq_out, dq_dev, dq;
	logic [31:0] reg_wdata, reg_rdata, rd, first;
	logic [19:0] flash_addr;
	logic [3:0] adds;
	int err_total, checks, cyc;
	// Wire level of the shared data bus
	assign dq = dq_oe ? dq_out : dq_dev;
	fsr_host_ctrl dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.flash_addr(flash_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq),
		.ready_busy_output(rb));
	fsr_flash_model fm_u (.clk(clk), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.dq(dq), .dq_dev(dq_dev), .ready_busy_output(rb), .stuck(stuck),
		.saw_reset_r(saw_reset), .adds_r(adds), .addr(flash_addr));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task give_verdict();
		if (err_total == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	// Hang guard, far above the expected run of about 1300 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			give_verdict();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
		checks = checks + 1;
		if (((got ^ exp) & mask) !== 32'h0) begin
			err_total = err_total + 1;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task rdr(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr
	// Start an operation and wait, bounded, for busy to drop
	task op(input fsr_op_t o);
		wr(`FSR_REG_CTRL, {29'h0, o});
		for (int i = 0; i < 300; i++) begin
			rdr(`FSR_REG_STATUS);
			if (rd[0] === 1'b0)
				break;
		end
		chk(rd, 32'h0, 32'h1);
	endtask : op
	initial begin
		{rst_n, reg_wr, reg_rd, stuck} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		{err_total, checks, cyc} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values and an unmapped address
		rdr(`FSR_REG_LIMIT);
		chk(rd, 32'h0000FFFF, '1);
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h80, '1);
		rdr(8'h20);
		chk(rd, 32'h0, '1);
		// Program, then status reads while the algorithm runs
		wr(`FSR_REG_ADDR, 32'h123);
		wr(`FSR_REG_WDATA, 32'h25);
		rdr(`FSR_REG_ADDR);
		chk(rd, 32'h123, '1);
		op(FSR_OP_WRITE);
		chk(rd, 32'h0, 32'h80);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd, 32'h80, '1);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd, 32'hC0, '1);
		op(FSR_OP_POLL);
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h82, '1);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd, 32'h11, '1);
		// Stuck program: round limit first, then the timing-limit failure
		stuck <= 1'b1;
		wr(`FSR_REG_LIMIT, 32'h2);
		op(FSR_OP_WRITE);
		op(FSR_OP_POLL);
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h40, 32'h44);
		wr(`FSR_REG_LIMIT, 32'h28);
		op(FSR_OP_POLL);
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h04, 32'h44);
		chk({31'h0, saw_reset}, 32'h1, '1);
		stuck <= 1'b0;
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h80, 32'h80);
		// Sector erase: window, restart by a second add, then lock-out
		op(FSR_OP_ERASE_ADD);
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h0, 32'hB8);
		op(FSR_OP_ERASE_ADD);
		chk({28'h0, adds}, 32'h2, '1);
		repeat (160) @(posedge clk);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd, 32'h0, 32'hA8);
		repeat (60) @(posedge clk);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		first = rd;
		chk(rd, 32'h08, 32'hA8);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd ^ first, 32'h44, 32'h44);
		op(FSR_OP_ERASE_ADD);
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h18, 32'hB8);
		chk({28'h0, adds}, 32'h2, '1);
		// Erase suspend: selected sector, other sector, program inside suspend, resume
		wr(`FSR_REG_WDATA, 32'hB0);
		op(FSR_OP_WRITE);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		first = rd;
		chk(rd, 32'h80, 32'hA0);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd ^ first, 32'h04, 32'h44);
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h80, 32'h80);
		wr(`FSR_REG_ADDR, 32'h40000);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd, 32'h11, '1);
		wr(`FSR_REG_WDATA, 32'h25);
		op(FSR_OP_WRITE);
		chk(rd, 32'h0, 32'h80);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd, 32'h80, 32'hA0);
		op(FSR_OP_POLL);
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h8A, '1);
		wr(`FSR_REG_WDATA, 32'h30);
		op(FSR_OP_WRITE);
		repeat (320) @(posedge clk);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd, 32'h11, '1);
		rdr(`FSR_REG_STATUS);
		chk(rd, 32'h80, 32'h80);
		// Chip erase: no time-out, window flag high at once
		wr(`FSR_REG_WDATA, 32'h10);
		op(FSR_OP_WRITE);
		op(FSR_OP_READ);
		rdr(`FSR_REG_RDATA);
		chk(rd, 32'h08, 32'hA8);
		give_verdict();
	end
endmodule : fsr_host_ctrl_tb_top
